// [cmp_out_cfg.svh]
// constants of the compare-output block: widths, bit positions, reset values
`ifndef CMP_OUT_CFG_SVH
`define CMP_OUT_CFG_SVH
// ==========================================
// widths
`define CMP_W 16
`define PORT_W 8
`define NBITS 24
`define T2_CHANS 5
`define P4_CHANS 8
// ==========================================
// bit positions inside the merged latch vectors
`define P1_BASE 0
`define P4_BASE 8
`define P5_BASE 16
`define CC4_IDX 4
// ==========================================
// reset values
`define LATCH_RST 24'hffffff
`endif

// [cmp_out_pkg.sv]
// types of the compare-output block
package cmp_out_pkg;
  // ==========================================
  // compare value carried between timer and register
  typedef logic [15:0] cmp_val_t;
  // the two compare modes of one output latch
  typedef enum logic {
    MODE_PWM = 1'b0,
    MODE_SHADOW = 1'b1
  } cmp_mode_t;
endpackage : cmp_out_pkg

// [cmp_out.sv]
// compare-output latches for port 1 bits 0-4, port 4 and port 5
`timescale 1ns/10ps
`default_nettype none
`include "cmp_out_cfg.svh"

module cmp_out
  import cmp_out_pkg::*;
(
  input wire logic i_clk_sys, // system clock, 25 MHz
  input wire logic i_rst_b, // synchronous reset, active low
  input wire logic [15:0] i_t2_count, // timer 2 count
  input wire logic i_t2_ovf, // timer 2 overflow, one-cycle pulse
  input wire logic [15:0] i_ct_count, // compare timer count
  input wire logic i_ct_ovf, // compare timer overflow, one-cycle pulse
  input wire logic [79:0] i_t2_cmp_vals, // five timer-2 compare values, register 0 lowest
  input wire logic [4:0] i_t2_cmp_en, // compare enable per timer-2 register
  input wire logic i_timer2_compare_mode_select, // mode for timer-2 registers 0-3
  input wire logic i_cc4_mode_sel, // mode for general_compare_register_4 on port 1 bit 4 only
  input wire logic [127:0] i_p4_cmp_vals, // eight port4_compare_registers, 0 lowest
  input wire logic [7:0] i_p4_cmp_en, // compare enable per port-4 register
  input wire logic [7:0] i_p4_ct_sel, // 1: compare timer base, 0: timer 2 base
  input wire logic [7:0] i_p5_cmp_en, // port-5 bits driven by register 4
  input wire logic i_p1_wr, // port 1 latch write strobe
  input wire logic [7:0] i_p1_wdata, // port 1 write data
  input wire logic i_p4_wr, // port 4 latch write strobe
  input wire logic [7:0] i_p4_wdata, // port 4 write data
  input wire logic i_p5_wr, // port 5 latch write strobe
  input wire logic [7:0] i_p5_wdata, // port 5 write data
  output logic [7:0] o_p1_pins, // port 1 pin level, also plain read value
  output logic [7:0] o_p4_pins, // port 4 pin level, also plain read value
  output logic [7:0] o_p5_pins, // port 5 pin level, also plain read value
  output logic [7:0] o_p1_shadow, // port 1 modify-write read value
  output logic [7:0] o_p4_shadow, // port 4 modify-write read value
  output logic [7:0] o_p5_shadow // port 5 modify-write read value
);

  // ==========================================
  // merged per-bit control
  logic [`NBITS-1:0] cmp_v; // bit is compare-controlled
  logic [`NBITS-1:0] mode1_v; // bit runs in shadow mode
  logic [`NBITS-1:0] match_v; // compare match level
  logic [`NBITS-1:0] ovf_v; // overflow of the assigned timer
  logic [`NBITS-1:0] wr_v; // write strobe per bit
  logic [`NBITS-1:0] wd_v; // write data per bit
  logic [`NBITS-1:0] out_r; // output latch, drives the pin
  logic [`NBITS-1:0] sh_r; // shadow latch
  logic [`NBITS-1:0] out_nxt; // next output latch
  logic [`NBITS-1:0] sh_nxt; // next shadow latch

  // equality of a count with a compare value
  function automatic logic cmp_eq(input cmp_val_t cnt, input cmp_val_t val);
    return cnt == val;
  endfunction : cmp_eq

  // next output latch of one bit
  function automatic logic next_out(input logic cmp, input logic m1, input logic mt,
                                    input logic ov, input logic wr, input logic wd,
                                    input logic out, input logic sh);
    logic r;
    r = out;
    if (!cmp) begin
      // plain port bit
      r = wr ? wd : out;
    end else if (!m1) begin
      // pwm: match set wins over overflow clear, writes ignored
      if (mt) begin
        r = 1'b1;
      end else if (ov) begin
        r = 1'b0;
      end
    end else if (mt) begin
      // shadow mode: transparent while the match holds
      r = wr ? wd : sh;
    end
    return r;
  endfunction : next_out

  // next shadow latch of one bit
  function automatic logic next_sh(input logic cmp, input logic wr, input logic wd,
                                   input logic out, input logic sh);
    logic r;
    r = wr ? wd : (cmp ? sh : out);
    return r;
  endfunction : next_sh

  // ==========================================
  // channel routing: timer, mode and match per bit
  always_comb begin
    cmp_v = '0;
    mode1_v = '0;
    match_v = '0;
    ovf_v = '0;
    for (int i = 0; i < `T2_CHANS; i++) begin
      cmp_v[`P1_BASE+i] = i_t2_cmp_en[i];
      match_v[`P1_BASE+i] = i_t2_cmp_en[i] & cmp_eq(i_t2_count, i_t2_cmp_vals[i*`CMP_W +: `CMP_W]);
      mode1_v[`P1_BASE+i] = (i == `CC4_IDX) ? i_cc4_mode_sel : i_timer2_compare_mode_select;
      ovf_v[`P1_BASE+i] = i_t2_ovf;
    end
    for (int i = 0; i < `P4_CHANS; i++) begin
      cmp_v[`P4_BASE+i] = i_p4_cmp_en[i];
      // compare timer forces pwm, timer 2 forces shadow
      mode1_v[`P4_BASE+i] = ~i_p4_ct_sel[i];
      match_v[`P4_BASE+i] = i_p4_cmp_en[i] &
        cmp_eq(i_p4_ct_sel[i] ? i_ct_count : i_t2_count, i_p4_cmp_vals[i*`CMP_W +: `CMP_W]);
      ovf_v[`P4_BASE+i] = i_p4_ct_sel[i] ? i_ct_ovf : i_t2_ovf;
    end
    for (int i = 0; i < `PORT_W; i++) begin
      // port 5 only under timer 2 in shadow mode
      cmp_v[`P5_BASE+i] = i_p5_cmp_en[i];
      mode1_v[`P5_BASE+i] = 1'b1;
      match_v[`P5_BASE+i] = i_p5_cmp_en[i] & i_t2_cmp_en[`CC4_IDX] &
        cmp_eq(i_t2_count, i_t2_cmp_vals[`CC4_IDX*`CMP_W +: `CMP_W]);
      ovf_v[`P5_BASE+i] = 1'b0;
    end
  end

  // write strobes and data fanned out per bit
  assign wr_v = {{`PORT_W{i_p5_wr}}, {`PORT_W{i_p4_wr}}, {`PORT_W{i_p1_wr}}};
  assign wd_v = {i_p5_wdata, i_p4_wdata, i_p1_wdata};

  // ==========================================
  // next latch values
  always_comb begin
    out_nxt = out_r;
    sh_nxt = sh_r;
    for (int b = 0; b < `NBITS; b++) begin
      // pwm bits rise on match, fall on overflow, writes ignored
      // set beats clear, spike left by equal widths
      out_nxt[b] = next_out(cmp_v[b], mode1_v[b], match_v[b], ovf_v[b], wr_v[b], wd_v[b],
                            out_r[b], sh_r[b]);
      sh_nxt[b] = next_sh(cmp_v[b], wr_v[b], wd_v[b], out_r[b], sh_r[b]);
    end
  end

  // output latches
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      out_r <= `LATCH_RST;
    end else begin
      out_r <= out_nxt;
    end
  end

  // shadow latches
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      sh_r <= `LATCH_RST;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  // ==========================================
  // read values
  // plain read sees the pin latch
  assign o_p1_pins = out_r[`P1_BASE +: `PORT_W];
  assign o_p4_pins = out_r[`P4_BASE +: `PORT_W];
  assign o_p5_pins = out_r[`P5_BASE +: `PORT_W];
  assign o_p1_shadow = sh_r[`P1_BASE +: `PORT_W];
  assign o_p4_shadow = sh_r[`P4_BASE +: `PORT_W];
  assign o_p5_shadow = sh_r[`P5_BASE +: `PORT_W];

  // ==========================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  for (genvar b = 0; b < `NBITS; b++) begin : g_chk
    // shadow write without match, then a match with no write
    sequence s_wr_then_match;
      (cmp_v[b] & mode1_v[b] & wr_v[b] & ~match_v[b]) ##1
      (cmp_v[b] & mode1_v[b] & match_v[b] & ~wr_v[b]);
    endsequence
    chk_pwm_rise: assert property (cmp_v[b] & ~mode1_v[b] & match_v[b] |=> out_r[b])
      else $error("pwm bit did not rise on match");
    chk_pwm_fall: assert property (cmp_v[b] & ~mode1_v[b] & ovf_v[b] & ~match_v[b] |=> !out_r[b])
      else $error("pwm bit did not fall on overflow");
    chk_pwm_write_ignored: assert property (cmp_v[b] & ~mode1_v[b] & ~match_v[b] & ~ovf_v[b]
      |=> out_r[b] == $past(out_r[b])) else $error("pwm bit moved without timer event");
    chk_shadow_hold: assert property (cmp_v[b] & mode1_v[b] & ~match_v[b]
      |=> out_r[b] == $past(out_r[b])) else $error("shadow bit pin moved without match");
    chk_shadow_late: assert property (s_wr_then_match |=> out_r[b] == $past(wd_v[b], 2))
      else $error("written level not on pin after match");
    chk_shadow_xfer: assert property (cmp_v[b] & mode1_v[b] & match_v[b] & ~wr_v[b]
      |=> out_r[b] == $past(sh_r[b])) else $error("pin did not take shadow at match");
    chk_transparent_wr: assert property (cmp_v[b] & mode1_v[b] & match_v[b] & wr_v[b]
      |=> out_r[b] == $past(wd_v[b]) && sh_r[b] == $past(wd_v[b]))
      else $error("latches not transparent during match");
    chk_shadow_wr: assert property (cmp_v[b] & wr_v[b] |=> sh_r[b] == $past(wd_v[b]))
      else $error("shadow did not take write");
  end

  for (genvar i = 0; i < `P4_CHANS; i++) begin : g_chk_p4
    chk_p4_auto_mode: assert property (i_p4_cmp_en[i] ##1 i_p4_ct_sel[i] & ~match_v[`P4_BASE+i]
      & i_ct_ovf & i_p4_cmp_en[i] |=> !out_r[`P4_BASE+i]) else $error("port 4 not low on overflow");
  end

endmodule : cmp_out
`default_nettype wire

// [cmp_load.sv]
// load model that sits on the compare output pins and counts rising edges
`timescale 1ns/10ps
`default_nettype none
module cmp_load (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_b, // synchronous reset, active low
  input wire logic [23:0] i_pins, // p5, p4, p1 pin levels
  output logic [15:0] o_rise_cnt // rising edges seen on all pins
);
  // ==========================================
  // edge counter, a pure load that never drives back
  logic [23:0] last_r; // pin levels one cycle ago
  always_ff @(posedge i_clk_sys) begin
    last_r <= i_pins;
    if (!i_rst_b) begin
      o_rise_cnt <= 16'h0000;
    end else begin
      o_rise_cnt <= o_rise_cnt + 16'($countones(i_pins & ~last_r));
    end
  end
endmodule : cmp_load
`default_nettype wire

// [tb_top.sv]
// self-checking bench of the compare-output latches
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cmp_out_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic i_clk_sys, i_rst_b, i_t2_ovf, i_ct_ovf, i_mode, i_cc4, i_p1_wr, i_p4_wr, i_p5_wr;
  logic [15:0] i_t2_count, i_ct_count;
  logic [7:0] i_p1_wdata, i_p4_wdata, i_p5_wdata, d;
  logic [7:0] o_p1_pins, o_p4_pins, o_p5_pins, o_p1_shadow, o_p4_shadow, o_p5_shadow, seen;
  logic [15:0] rise_cnt; // rising edges counted by the load model
  typedef struct packed {logic [2:0] sel; logic [7:0] mask; logic [7:0] exp;} note_t;
  note_t note_q[$]; // expected results, oldest first
  note_t n; // note being compared
  int error_cnt = 0;
  int tests_run = 0;
  cmp_out u_cmp_out (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_t2_count(i_t2_count), .i_t2_ovf(i_t2_ovf),
    .i_ct_count(i_ct_count), .i_ct_ovf(i_ct_ovf),
    .i_t2_cmp_vals({16'h0040, 16'h0000, 16'h0000, 16'h0020, 16'h0010}), .i_t2_cmp_en(5'h13),
    .i_timer2_compare_mode_select(i_mode), .i_cc4_mode_sel(i_cc4), .i_p4_cmp_vals({96'h0, 16'h0050, 16'h0030}),
    .i_p4_cmp_en(8'h03), .i_p4_ct_sel(8'h01), .i_p5_cmp_en(8'hff), .i_p1_wr(i_p1_wr), .i_p1_wdata(i_p1_wdata),
    .i_p4_wr(i_p4_wr), .i_p4_wdata(i_p4_wdata), .i_p5_wr(i_p5_wr), .i_p5_wdata(i_p5_wdata),
    .o_p1_pins(o_p1_pins), .o_p4_pins(o_p4_pins), .o_p5_pins(o_p5_pins), .o_p1_shadow(o_p1_shadow),
    .o_p4_shadow(o_p4_shadow), .o_p5_shadow(o_p5_shadow));
  cmp_load u_cmp_load (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_pins({o_p5_pins, o_p4_pins, o_p1_pins}),
    .o_rise_cnt(rise_cnt));
  // ==========================================
  // clock, 40 ns period
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // ==========================================
  // comparison, verdict and watchdog
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
  // monitor: after each edge settles, take the oldest note and compare
  always @(posedge i_clk_sys) begin
    #1;
    if (note_q.size() > 0) begin
      n = note_q.pop_front();
      case (n.sel)
        3'd0: seen = o_p1_pins;
        3'd1: seen = o_p4_pins;
        3'd2: seen = o_p5_pins;
        3'd3: seen = o_p1_shadow;
        3'd4: seen = o_p4_shadow;
        3'd5: seen = o_p5_shadow;
        // rise count of the load, low byte
        default: seen = rise_cnt[7:0];
      endcase
      check(seen & n.mask, n.exp & n.mask);
    end
  end
  // note one expectation, let the edge pass, drop strobes on that edge
  task automatic go(input logic [2:0] s, input logic [7:0] m, input logic [7:0] e);
    note_q.push_back('{s, m, e});
    @(posedge i_clk_sys);
    {i_p1_wr, i_p4_wr, i_p5_wr, i_t2_ovf, i_ct_ovf} <= 5'h00;
    i_t2_count <= 16'h0001;
    i_ct_count <= 16'h0001;
    @(negedge i_clk_sys);
  endtask : go
  // ==========================================
  // main sequence, inputs move on the falling edge
  initial begin
    {i_rst_b, i_p1_wr, i_p4_wr, i_p5_wr, i_t2_ovf, i_ct_ovf, i_mode, i_cc4} = 8'h01;
    {i_t2_count, i_ct_count} = {16'h0001, 16'h0001};
    {i_p1_wdata, i_p4_wdata, i_p5_wdata} = 24'h0;
    void'($urandom(32'h98de5805));
    repeat (20) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    go(3'd0, 8'hff, 8'hff);
    go(3'd5, 8'hff, 8'hff);
    i_t2_ovf = 1'b1;
    go(3'd0, 8'h03, 8'h00);
    {i_p1_wr, i_p1_wdata} = 9'h1ff;
    go(3'd0, 8'h03, 8'h00);
    i_t2_count = 16'h0010;
    go(3'd0, 8'h03, 8'h01);
    {i_t2_ovf, i_t2_count} = {1'b1, 16'h0010};
    go(3'd0, 8'h01, 8'h01);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      {i_p1_wr, i_p1_wdata} = {1'b1, d};
      go(3'd0, 8'he0, d);
    end
    {i_mode, i_p1_wr, i_p1_wdata} = 10'h300;
    go(3'd0, 8'h02, 8'h00);
    {i_p1_wr, i_p1_wdata} = 9'h102;
    go(3'd3, 8'h02, 8'h02);
    go(3'd0, 8'h02, 8'h00);
    i_t2_count = 16'h0020;
    go(3'd0, 8'h02, 8'h02);
    {i_t2_count, i_p1_wr, i_p1_wdata} = {16'h0020, 9'h100};
    go(3'd0, 8'h02, 8'h00);
    i_ct_ovf = 1'b1;
    go(3'd1, 8'h01, 8'h00);
    {i_p4_wr, i_p4_wdata} = 9'h1ff;
    go(3'd1, 8'h01, 8'h00);
    i_ct_count = 16'h0030;
    go(3'd1, 8'h01, 8'h01);
    {i_p4_wr, i_p4_wdata} = 9'h100;
    go(3'd1, 8'h02, 8'h02);
    // port 4 shadows hold the last write, pwm bit included
    go(3'd4, 8'hff, 8'h00);
    i_t2_count = 16'h0050;
    go(3'd1, 8'h02, 8'h00);
    {i_p5_wr, i_p5_wdata} = 9'h15a;
    go(3'd5, 8'hff, 8'h5a);
    i_t2_count = 16'h0040;
    go(3'd2, 8'hff, 8'h5a);
    i_rst_b = 1'b0;
    go(3'd0, 8'hff, 8'hff);
    i_rst_b = 1'b1;
    go(3'd2, 8'hff, 8'hff);
    // reset lifted the eighteen low pins, the load saw each rise once
    go(3'd6, 8'hff, 8'h12);
    repeat (2) @(negedge i_clk_sys);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
